/* shared/supervisor_defs.vh */
// constants for the input regulator supervisor and clock select block
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH
`define CLK_SYS_MHZ 200
`define TICK_32K_HZ 32768
`define TICK_32K_DIV ((`CLK_SYS_MHZ * 1000000) / `TICK_32K_HZ)
`define FAST_16M_DIV 13'h000C
`define SEQ_STEP_SHORT_US 500
`define SEQ_STEP_LONG_US 2000
`define SEQ_STEP_SHORT_TICKS ((`SEQ_STEP_SHORT_US * `TICK_32K_HZ + 999999) / 1000000)
`define SEQ_STEP_LONG_TICKS ((`SEQ_STEP_LONG_US * `TICK_32K_HZ + 999999) / 1000000)
`define OV_FILTER_US 122
`define OV_FILTER_TICKS ((`OV_FILTER_US * `TICK_32K_HZ + 999999) / 1000000)
`define SLOT_OFF 3'h0
`define SLOT_LAST 3'h7
`define SUPPLY_OV_BIT 2
`define REF_LOCAL 1'b0
`define REF_MAIN 1'b1
`define IREG_MODE_ON 2'h0
`define IREG_MODE_LP 2'h1
`define IREG_MODE_OFF_LP 2'h2
`endif

/* src/tick_divider.v */
// divider that turns clk_sys into a one-cycle enable pulse
`timescale 1ns/10ps
module tick_divider #(
   parameter WIDTH = 13,
   parameter [WIDTH-1:0] DIVIDE = 13'h0006
) (
   input wire clk_sys,
   input wire reset,
   input wire run,
   output reg tick
);
   reg [WIDTH-1:0] count_reg;

   always @(posedge clk_sys) begin
      if (reset || !run) begin
         count_reg <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (count_reg == DIVIDE - 1'b1) begin
         count_reg <= {WIDTH{1'b0}};
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

/* src/tick_filter.v */
// debounce: level must hold for LENGTH ticks before the output follows it
`timescale 1ns/10ps
module tick_filter #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] LENGTH = 8'h04
) (
   input wire clk_sys,
   input wire reset,
   input wire tick,
   input wire level_in,
   output reg level_out
);
   reg [WIDTH-1:0] count_reg;

   always @(posedge clk_sys) begin
      if (reset) begin
         count_reg <= {WIDTH{1'b0}};
         level_out <= 1'b0;
      end else if (level_in == level_out) begin
         count_reg <= {WIDTH{1'b0}};
      end else if (tick) begin
         if (count_reg == LENGTH - 1'b1) begin
            count_reg <= {WIDTH{1'b0}};
            level_out <= level_in;
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule

/* src/input_ldo_supervisor_clock_select.v */
// clock selection, start-up sequencer and front-end input regulator supervisor
//
// Contract
// - sequencing step period chosen by one-time config: 500 us or 2000 us.
// - every sequencing step is timed from the trimmed 32 kHz tick.
// - untrimmed 32 kHz for the general debounce only when input low, all asleep, or all PFM.
// - trimmed tick used in start-up above threshold and button config 1 debounce.
// - in on state with 16 MHz running, the over-voltage debounce uses trimmed tick.
// - low-input interrupt debounces from the untrimmed tick always; button does too except in config 1 with the trimmed tick selected.
// - switching frequency of all bucks comes from trimmed 16 MHz.
// - input regulator starts on local reference, moves to main at threshold.
// - standby puts input regulator into low power unless disable bit set.
// - sleep always puts input regulator into low power.
// - off state uses a separate, further reduced input regulator mode.
// - excessive droop on regulated input turns external pass transistor off.
// - supply over-voltage raises interrupt and sets bit 2 of status three.
// - interrupt output low for over-voltage only while its mask is clear.
// - over-voltage must persist 122 us before being flagged.
// - over-voltage during start-up sequence raises no interrupt.
// - real-time over-voltage sense bit is readable by the host.
// - memory reference slot equals the third buck's slot.
// - card supply default voltage follows the card voltage-select pin.
`timescale 1ns/10ps
`include "supervisor_defs.vh"
module input_ldo_supervisor_clock_select #(
   parameter NUM_REG = 8,
   parameter TICK_DIV = `TICK_32K_DIV,
   parameter SHORT_TICKS = `SEQ_STEP_SHORT_TICKS,
   parameter LONG_TICKS = `SEQ_STEP_LONG_TICKS,
   parameter OV_TICKS = `OV_FILTER_TICKS
) (
   input wire clk_sys,
   input wire reset,
   // one-time configuration
   input wire seq_step_long,
   input wire button_debounce_cfg,
   input wire [3*NUM_REG-1:0] reg_slots,
   input wire [2:0] buck_three_slot,
   input wire standby_lp_disable,
   // analog status and state
   input wire start_request,
   input wire vin_above_uv,
   input wire vin_droop,
   input wire ov_detect,
   input wire low_input_det,
   input wire button_det,
   input wire all_sleep,
   input wire all_pfm,
   input wire state_standby,
   input wire state_sleep,
   input wire state_off,
   input wire card_voltage_select,
   // host side
   input wire supply_ov_mask,
   input wire supply_ov_clear,
   // outputs
   output reg [NUM_REG-1:0] reg_enable,
   output reg [2:0] mem_ref_slot,
   output reg card_volt_high,
   output reg sequence_done,
   output reg use_untrimmed,
   output reg fast_clk_tick,
   output reg ref_main,
   output reg [1:0] input_reg_ctrl,
   output reg ext_pass_on,
   output reg [7:0] irq_status_three,
   output reg supply_ov_sense,
   output reg low_input_irq,
   output reg power_button_irq,
   output reg irq_out_n
);
   // ----------------------------------------
   // clock ticks
   // ----------------------------------------
   // the trimmed 32 kHz tick is a divide of clk_sys; the untrimmed one is
   // modelled by a second, free divider with its own (slightly off) ratio
   wire trim_tick;
   wire raw_tick;
   wire fast_tick;
   wire untrim_sel;
   reg seq_active_reg;

   assign untrim_sel = !vin_above_uv || all_sleep || all_pfm;

   tick_divider #(.WIDTH(16), .DIVIDE(TICK_DIV[15:0])) u_trim_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(1'b1),
      .tick(trim_tick)
   );

   tick_divider #(.WIDTH(16), .DIVIDE(TICK_DIV[15:0] + 16'h0010)) u_raw_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(1'b1),
      .tick(raw_tick)
   );

   // switching clock enable for the bucks, always from the trimmed source
   tick_divider #(.WIDTH(13), .DIVIDE(`FAST_16M_DIV)) u_fast_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(1'b1),
      .tick(fast_tick)
   );

   // general debounce tick: trimmed unless the untrimmed source is forced
   wire deb_tick;
   wire button_tick;
   assign deb_tick = untrim_sel ? raw_tick : trim_tick;
   assign button_tick = (button_debounce_cfg && !untrim_sel) ? trim_tick : raw_tick;

   // ----------------------------------------
   // start-up sequencer
   // ----------------------------------------
   reg [11:0] step_cnt_reg;
   reg [2:0] slot_reg;
   wire [11:0] step_len;
   assign step_len = seq_step_long ? LONG_TICKS[11:0] : SHORT_TICKS[11:0];

   always @(posedge clk_sys) begin
      if (reset) begin
         seq_active_reg <= 1'b0;
         step_cnt_reg <= 12'h000;
         slot_reg <= 3'h0;
         sequence_done <= 1'b0;
      end else if (!seq_active_reg) begin
         if (start_request && vin_above_uv && !sequence_done) begin
            seq_active_reg <= 1'b1;
            step_cnt_reg <= 12'h000;
            slot_reg <= 3'h1;
         end
      end else if (trim_tick) begin
         if (step_cnt_reg == step_len - 12'h001) begin
            step_cnt_reg <= 12'h000;
            if (slot_reg == `SLOT_LAST) begin
               seq_active_reg <= 1'b0;
               sequence_done <= 1'b1;
            end else begin
               slot_reg <= slot_reg + 3'h1;
            end
         end else begin
            step_cnt_reg <= step_cnt_reg + 12'h001;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_REG; g = g + 1) begin : g_en
         always @(posedge clk_sys) begin
            if (reset) begin
               reg_enable[g] <= 1'b0;
            end else if (seq_active_reg && reg_slots[3*g +: 3] != `SLOT_OFF &&
                         reg_slots[3*g +: 3] == slot_reg) begin
               reg_enable[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // input regulator control
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (reset) begin
         mem_ref_slot <= 3'h0;
         card_volt_high <= 1'b0;
         use_untrimmed <= 1'b1;
         fast_clk_tick <= 1'b0;
         ref_main <= `REF_LOCAL;
         input_reg_ctrl <= `IREG_MODE_ON;
         ext_pass_on <= 1'b0;
      end else begin
         mem_ref_slot <= buck_three_slot;
         card_volt_high <= card_voltage_select;
         use_untrimmed <= untrim_sel;
         fast_clk_tick <= fast_tick;
         if (vin_above_uv) begin
            ref_main <= `REF_MAIN;
         end
         if (state_off) begin
            input_reg_ctrl <= `IREG_MODE_OFF_LP;
         end else if (state_sleep) begin
            input_reg_ctrl <= `IREG_MODE_LP;
         end else if (state_standby && !standby_lp_disable) begin
            input_reg_ctrl <= `IREG_MODE_LP;
         end else begin
            input_reg_ctrl <= `IREG_MODE_ON;
         end
         // pass transistor off on droop and whenever low power path is used
         ext_pass_on <= !vin_droop && !state_off && !state_sleep &&
                        !(state_standby && !standby_lp_disable);
      end
   end

   // ----------------------------------------
   // over-voltage and other interrupts
   // ----------------------------------------
   wire ov_filt;
   wire low_filt;
   wire button_filt;
   reg ov_filt_d_reg;

   tick_filter #(.WIDTH(8), .LENGTH(OV_TICKS[7:0])) u_ov_filt (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(deb_tick),
      .level_in(ov_detect),
      .level_out(ov_filt)
   );

   tick_filter #(.WIDTH(8), .LENGTH(OV_TICKS[7:0])) u_low_filt (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(raw_tick),
      .level_in(low_input_det),
      .level_out(low_filt)
   );

   tick_filter #(.WIDTH(8), .LENGTH(OV_TICKS[7:0])) u_button_filt (
      .clk_sys(clk_sys),
      .reset(reset),
      .tick(button_tick),
      .level_in(button_det),
      .level_out(button_filt)
   );

   always @(posedge clk_sys) begin
      if (reset) begin
         ov_filt_d_reg <= 1'b0;
         irq_status_three <= 8'h00;
         supply_ov_sense <= 1'b0;
         low_input_irq <= 1'b0;
         power_button_irq <= 1'b0;
         irq_out_n <= 1'b1;
      end else begin
         ov_filt_d_reg <= ov_filt;
         supply_ov_sense <= ov_filt;
         low_input_irq <= low_filt;
         power_button_irq <= button_filt;
         // a new rising edge wins over a clear in the same cycle
         if (ov_filt && !ov_filt_d_reg && !seq_active_reg) begin
            irq_status_three[`SUPPLY_OV_BIT] <= 1'b1;
         end else if (supply_ov_clear) begin
            irq_status_three[`SUPPLY_OV_BIT] <= 1'b0;
         end
         irq_out_n <= !(irq_status_three[`SUPPLY_OV_BIT] && !supply_ov_mask);
      end
   end
endmodule

/* verification/supervisor_monitor.sv */
// assertion checker for the supervisor and clock select block
`timescale 1ns/10ps
module supervisor_monitor (
   input wire clk_sys,
   input wire reset,
   input wire vin_droop,
   input wire state_sleep,
   input wire state_off,
   input wire ov_detect,
   input wire supply_ov_mask,
   input wire card_voltage_select,
   input wire card_volt_high,
   input wire ref_main,
   input wire [1:0] input_reg_ctrl,
   input wire ext_pass_on,
   input wire [7:0] irq_status_three,
   input wire supply_ov_sense,
   input wire irq_out_n
);
   // ----
   // properties
   // ----
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_card_follow: assert property (1 |=> card_volt_high == $past(card_voltage_select))
      else $error("card level wrong");
   a_mask_quiet: assert property (supply_ov_mask |=> irq_out_n)
      else $error("masked irq low");
   a_irq_hold: assert property (irq_status_three[2] && !supply_ov_mask |=> !irq_out_n)
      else $error("irq not held");
   a_spare_zero: assert property (irq_status_three[7:3] == 5'h0 && irq_status_three[1:0] == 2'h0)
      else $error("spare bits set");
   a_sense_filter: assert property ($rose(supply_ov_sense) |-> $past(ov_detect) && $past(ov_detect, 4))
      else $error("sense unfiltered");
   a_ref_sticky: assert property (ref_main |=> ref_main)
      else $error("ref left main");
   a_droop_off: assert property (vin_droop |=> !ext_pass_on)
      else $error("pass on in droop");
   a_sleep_lp: assert property (state_sleep && !state_off |=> input_reg_ctrl == 2'h1)
      else $error("sleep not low power");
endmodule
bind input_ldo_supervisor_clock_select supervisor_monitor supervisor_monitor_i (.clk_sys, .reset,
   .vin_droop, .state_sleep, .state_off, .ov_detect, .supply_ov_mask, .card_voltage_select,
   .card_volt_high, .ref_main, .input_reg_ctrl, .ext_pass_on, .irq_status_three,
   .supply_ov_sense, .irq_out_n);

/* verification/host_model.sv */
// host processor model that services the over-voltage interrupt
`timescale 1ns/10ps
module host_model (
   input wire clk_sys,
   input wire serve,
   input wire irq_out_n,
   input wire supply_ov_sense,
   output reg supply_ov_clear
);
   // ----
   // service
   // ----
   initial supply_ov_clear = 1'b0;
   // clears only once the live sense reads quiet, else the event would be lost
   always @(posedge clk_sys) begin
      supply_ov_clear <= serve && !irq_out_n && !supply_ov_sense && !supply_ov_clear;
   end
endmodule

/* verification/input_ldo_supervisor_clock_select_test.sv */
// self-checking bench for the supervisor and clock select block
`timescale 1ns/10ps
module input_ldo_supervisor_clock_select_test;
   // ----
   // stimulus and wiring
   // ----
   reg clk_sys = 1'b0;
   reg reset = 1'b1;
   reg seq_step_long = 1'b0;
   reg [23:0] reg_slots = 24'h00_01d1;
   reg [9:0] row_in = 10'h000;
   reg start_request = 1'b0;
   reg vin_above_uv = 1'b0;
   reg vin_droop = 1'b0;
   reg ov_detect = 1'b0;
   reg supply_ov_mask = 1'b1;
   reg serve = 1'b0;
   reg button_debounce_cfg = 1'b0;
   reg low_input_det = 1'b0;
   reg button_det = 1'b0;
   wire low_input_irq, power_button_irq, fast_clk_tick;
   wire supply_ov_clear;
   wire [7:0] reg_enable;
   wire [2:0] mem_ref_slot;
   wire [1:0] input_reg_ctrl;
   wire [7:0] irq_status_three;
   wire card_volt_high, sequence_done, use_untrimmed, ref_main, ext_pass_on;
   wire supply_ov_sense, irq_out_n;
   integer n_errors = 0;
   integer n_compared = 0;
   integer i, n;
   // row input: standby, sleep, off, lp disable, card select, slot, all sleep, all pfm
   reg [9:0] in_rows [0:4] = '{10'h02c, 10'h215, 10'h25c, 10'h166, 10'h082};
   reg [7:0] out_rows [0:4] = '{8'h16, 8'h2b, 8'h0e, 8'h33, 8'h41};
   input_ldo_supervisor_clock_select #(.TICK_DIV(8), .SHORT_TICKS(3), .LONG_TICKS(5),
      .OV_TICKS(2)) input_ldo_supervisor_clock_select_i (
      .clk_sys, .reset, .seq_step_long, .button_debounce_cfg, .reg_slots,
      .buck_three_slot(row_in[4:2]), .standby_lp_disable(row_in[6]), .start_request,
      .vin_above_uv, .vin_droop, .ov_detect, .low_input_det, .button_det,
      .all_sleep(row_in[1]), .all_pfm(row_in[0]), .state_standby(row_in[9]),
      .state_sleep(row_in[8]), .state_off(row_in[7]), .card_voltage_select(row_in[5]),
      .supply_ov_mask, .supply_ov_clear, .reg_enable, .mem_ref_slot, .card_volt_high,
      .sequence_done, .use_untrimmed, .fast_clk_tick, .ref_main, .input_reg_ctrl,
      .ext_pass_on, .irq_status_three, .supply_ov_sense, .low_input_irq,
      .power_button_irq, .irq_out_n);
   host_model host_model_i (.clk_sys, .serve, .irq_out_n, .supply_ov_sense,
      .supply_ov_clear);
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task cyc(input integer k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task wait_en(input integer b);
      n = 0;
      while (reg_enable[b] !== 1'b1 && n < 999) begin
         cyc(1);
         n = n + 1;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----
   // tests
   // ----
   initial begin
      cyc(12);
      chk({4'h0, use_untrimmed, ref_main, irq_out_n, reg_enable[0]}, 8'h0a);
      @(posedge clk_sys) reset <= 1'b0;
      cyc(3);
      chk({6'h00, use_untrimmed, ref_main}, 8'h02);
      @(posedge clk_sys) vin_above_uv <= 1'b1;
      for (i = 0; i < 5; i = i + 1) begin
         @(posedge clk_sys) row_in <= in_rows[i];
         cyc(3);
         chk({1'b0, input_reg_ctrl, card_volt_high, mem_ref_slot, use_untrimmed}, out_rows[i]);
      end
      chk({7'h00, ref_main}, 8'h01);
      @(posedge clk_sys) vin_droop <= 1'b1;
      cyc(2);
      chk({7'h00, ext_pass_on}, 8'h00);
      @(posedge clk_sys) begin
         vin_droop <= 1'b0;
         row_in <= 10'h000;
      end
      // over-voltage held from start until the slot 7 enable must stay silent afterwards
      for (i = 0; i < 2; i = i + 1) begin
         @(posedge clk_sys) begin
            reset <= 1'b1;
            seq_step_long <= i[0];
         end
         cyc(12);
         @(posedge clk_sys) begin
            reset <= 1'b0;
            start_request <= 1'b1;
            ov_detect <= 1'b1;
         end
         wait_en(1);
         chk(reg_enable, 8'h03);
         wait_en(2);
         chk(n[7:0], i ? 8'hc8 : 8'h78);
         @(posedge clk_sys) ov_detect <= 1'b0;
         cyc(48);
         chk(reg_enable, 8'h07);
         chk({5'h00, sequence_done, irq_status_three[2], irq_out_n}, 8'h05);
      end
      @(posedge clk_sys) ov_detect <= 1'b1;
      cyc(4);
      @(posedge clk_sys) ov_detect <= 1'b0;
      cyc(30);
      chk(irq_status_three, 8'h00);
      @(posedge clk_sys) ov_detect <= 1'b1;
      cyc(30);
      chk(irq_status_three, 8'h04);
      chk({6'h00, supply_ov_sense, irq_out_n}, 8'h03);
      @(posedge clk_sys) supply_ov_mask <= 1'b0;
      cyc(3);
      chk({7'h00, irq_out_n}, 8'h00);
      @(posedge clk_sys) ov_detect <= 1'b0;
      cyc(30);
      chk({6'h00, supply_ov_sense, irq_status_three[2]}, 8'h01);
      @(posedge clk_sys) serve <= 1'b1;
      cyc(5);
      chk({6'h00, irq_out_n, irq_status_three[2]}, 8'h02);
      // switching enable pulses once every twelve clocks
      n = 0;
      repeat (24) begin
         cyc(1);
         n = n + fast_clk_tick;
      end
      chk(n[7:0], 8'h02);
      // button on trimmed tick (every 8) beats low-input on untrimmed tick (every 24)
      @(posedge clk_sys) begin
         button_debounce_cfg <= 1'b1;
         button_det <= 1'b1;
         low_input_det <= 1'b1;
      end
      cyc(20);
      chk({6'h00, power_button_irq, low_input_irq}, 8'h02);
      cyc(40);
      chk({6'h00, power_button_irq, low_input_irq}, 8'h03);
      stop_test;
   end
   // the run needs under a thousand cycles, so four thousand means a hang
   initial begin
      #20000;
      n_errors = n_errors + 1;
      stop_test;
   end
endmodule
